//--- inc/pll_div_consts.vh
// constants for the pll loop divider control block
//
// Summary of operation
// - mode 00 normal, 01 async power-down (reset), 10 unused, 11 sync power-down.
// - reference divider is 14 bits; low byte at 0x011, resets to 0x01.
// - reference divider bits 13:8 in 0x012 bits 5:0, reset 0x00.
// - swallow count is 6 bits in 0x013 bits 5:0, reset zero.
// - main feedback count is 13 bits; low byte at 0x014, resets to 0x03.
// - main feedback bits 12:8 in 0x015 bits 4:0, reset 0x00.
// - control bit 7 forces charge pump output to half its supply.
// - control bit 6 holds the reference divider in reset.
// - control bit 5 holds swallow and main feedback counters in reset.
// - control bit 4 holds all three counters in reset.
// - control bit 3 bypasses main feedback counter; only for fixed divide mode (the logic also bypasses it in dual modulus mode).
// - dual modulus uses high ratio while swallow nonzero, low ratio when zero.
`ifndef PLL_DIV_CONSTS_VH
`define PLL_DIV_CONSTS_VH

`define ADDR_W            10
`define ADDR_PLL_MODE     10'h010
`define ADDR_REF_LOW      10'h011
`define ADDR_REF_HIGH     10'h012
`define ADDR_SWALLOW      10'h013
`define ADDR_FB_LOW       10'h014
`define ADDR_FB_HIGH      10'h015
`define ADDR_DIV_CTRL     10'h016

`define RST_PLL_MODE      2'h1
`define RST_REF_LOW       8'h01
`define RST_REF_HIGH      6'h00
`define RST_SWALLOW       6'h00
`define RST_FB_LOW        8'h03
`define RST_FB_HIGH       5'h00
`define RST_DIV_CTRL      5'h00

`define MODE_NORMAL       2'h0
`define MODE_PD_ASYNC     2'h1
`define MODE_UNUSED       2'h2
`define MODE_PD_SYNC      2'h3

`define CTRL_CP_MID_BIT   7
`define CTRL_RST_REF_BIT  6
`define CTRL_RST_FB_BIT   5
`define CTRL_RST_ALL_BIT  4
`define CTRL_BYPASS_BIT   3

`define REF_W             14
`define SWALLOW_W         6
`define FB_W              13

`endif

//--- hdl/ref_divider.v
// reference divider counter
`timescale 1ns/100ps
`default_nettype none
`include "pll_div_consts.vh"
module ref_divider
(
    // clock and control
    input  wire                  core_clk_i,
    input  wire                  reset_n_i,
    input  wire                  clk_en_i,
    input  wire                  hold_i,
    // counting
    input  wire                  tick_i,
    input  wire [`REF_W-1:0]     div_val_i,
    output reg                   div_pulse_o
);

    reg [`REF_W-1:0] cnt_ff;
    wire             last;

    // divide by zero behaves as divide by one
    assign last = (div_val_i == {`REF_W{1'b0}}) ||
                  (cnt_ff == div_val_i - {{(`REF_W-1){1'b0}}, 1'b1});

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt_ff      <= {`REF_W{1'b0}};
            div_pulse_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (hold_i)
            begin
                cnt_ff      <= {`REF_W{1'b0}};
                div_pulse_o <= 1'b0;
            end
            else if (tick_i)
            begin
                div_pulse_o <= last;
                cnt_ff      <= last ? {`REF_W{1'b0}} : cnt_ff + {{(`REF_W-1){1'b0}}, 1'b1};
            end
            else
            begin
                div_pulse_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

//--- hdl/feedback_divider.v
// swallow and main feedback counters with modulus control
`timescale 1ns/100ps
`default_nettype none
`include "pll_div_consts.vh"
module feedback_divider
(
    // clock and control
    input  wire                  core_clk_i,
    input  wire                  reset_n_i,
    input  wire                  clk_en_i,
    input  wire                  hold_i,
    // configuration
    input  wire                  dual_modulus_mode_i,
    input  wire                  bypass_i,
    input  wire [`SWALLOW_W-1:0] swallow_i,
    input  wire [`FB_W-1:0]      main_i,
    // prescaler side
    input  wire                  tick_i,
    output reg                   modulus_hi_o,
    output reg                   fb_pulse_o
);

    reg  [`FB_W-1:0]      main_cnt_ff;
    reg  [`SWALLOW_W-1:0] swallow_cnt_ff;
    wire                  main_last;
    wire                  swallow_done;

    assign main_last    = bypass_i || (main_i == {`FB_W{1'b0}}) ||
                          (main_cnt_ff == main_i - {{(`FB_W-1){1'b0}}, 1'b1});
    assign swallow_done = (swallow_cnt_ff == swallow_i);

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            main_cnt_ff    <= {`FB_W{1'b0}};
            swallow_cnt_ff <= {`SWALLOW_W{1'b0}};
            modulus_hi_o   <= 1'b0;
            fb_pulse_o     <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (hold_i)
            begin
                main_cnt_ff    <= {`FB_W{1'b0}};
                swallow_cnt_ff <= {`SWALLOW_W{1'b0}};
                modulus_hi_o   <= 1'b0;
                fb_pulse_o     <= 1'b0;
            end
            else if (tick_i)
            begin
                fb_pulse_o <= main_last;
                if (main_last)
                begin
                    main_cnt_ff    <= {`FB_W{1'b0}};
                    swallow_cnt_ff <= {`SWALLOW_W{1'b0}};
                    modulus_hi_o   <= dual_modulus_mode_i &&
                                      (swallow_i != {`SWALLOW_W{1'b0}});
                end
                else
                begin
                    main_cnt_ff <= main_cnt_ff + {{(`FB_W-1){1'b0}}, 1'b1};
                    if (!swallow_done)
                    begin
                        swallow_cnt_ff <= swallow_cnt_ff + {{(`SWALLOW_W-1){1'b0}}, 1'b1};
                    end
                    modulus_hi_o <= dual_modulus_mode_i && !swallow_done &&
                                    (swallow_cnt_ff + {{(`SWALLOW_W-1){1'b0}}, 1'b1}
                                     != swallow_i);
                end
            end
            else
            begin
                fb_pulse_o   <= 1'b0;
                modulus_hi_o <= dual_modulus_mode_i && !swallow_done;
            end
        end
    end

endmodule
`default_nettype wire

//--- hdl/pll_divider_control.v
// pll loop divider control: registers, mode decode, counter holds
`timescale 1ns/100ps
`default_nettype none
`include "pll_div_consts.vh"
module pll_divider_control
(
    // clock and reset
    input  wire                 core_clk_i,
    input  wire                 reset_n_i,
    input  wire                 clk_en_i,
    // register port
    input  wire [`ADDR_W-1:0]   reg_addr_i,
    input  wire [7:0]           reg_wdata_i,
    input  wire                 reg_wr_i,
    input  wire                 reg_rd_i,
    output reg  [7:0]           reg_rdata_o,
    // divider clocks and prescaler mode from pins
    input  wire                 ref_clk_i,
    input  wire                 prescaler_clk_i,
    input  wire                 dual_modulus_mode_i,
    // pll mode
    output reg                  pll_normal_o,
    output reg                  pll_pd_async_o,
    output reg                  pll_pd_sync_o,
    // charge pump
    output reg                  charge_pump_output_mid_o,
    // counter holds
    output reg                  ref_hold_o,
    output reg                  fb_hold_o,
    // divider outputs
    output wire                 ref_pulse_o,
    output wire                 fb_pulse_o,
    output wire                 modulus_hi_o
);

    // register storage
    reg [1:0]            pll_mode_ff;
    reg [7:0]            ref_low_ff;
    reg [5:0]            ref_high_ff;
    reg [5:0]            swallow_ff;
    reg [7:0]            fb_low_ff;
    reg [4:0]            fb_high_ff;
    reg [4:0]            div_ctrl_ff;

    // pin synchronisers and edge detect
    reg [2:0]            ref_sync_ff;
    reg [2:0]            pre_sync_ff;
    reg [1:0]            dual_sync_ff;

    wire                 ref_tick;
    wire                 pre_tick;
    wire                 dual_mode;
    wire                 cp_mid;
    wire                 rst_ref;
    wire                 rst_fb;
    wire                 rst_all;
    wire                 bypass;
    wire                 loop_run;
    wire [`REF_W-1:0]    ref_div_val;
    wire [`FB_W-1:0]     fb_div_val;
    reg  [7:0]           nxt_rdata;
    // next values of the mode and hold outputs
    reg                  nxt_pll_normal;
    reg                  nxt_pll_pd_async;
    reg                  nxt_pll_pd_sync;
    reg                  nxt_ref_hold;
    reg                  nxt_fb_hold;

    // address match used by both write and read decode
    function sel;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    // register writes
    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            pll_mode_ff <= `RST_PLL_MODE;
            ref_low_ff  <= `RST_REF_LOW;
            ref_high_ff <= `RST_REF_HIGH;
            swallow_ff  <= `RST_SWALLOW;
            fb_low_ff   <= `RST_FB_LOW;
            fb_high_ff  <= `RST_FB_HIGH;
            div_ctrl_ff <= `RST_DIV_CTRL;
        end
        else if (clk_en_i && reg_wr_i)
        begin
            if (sel(reg_addr_i, `ADDR_PLL_MODE))
            begin
                pll_mode_ff <= reg_wdata_i[1:0];
            end
            else if (sel(reg_addr_i, `ADDR_REF_LOW))
            begin
                ref_low_ff <= reg_wdata_i;
            end
            else if (sel(reg_addr_i, `ADDR_REF_HIGH))
            begin
                ref_high_ff <= reg_wdata_i[5:0];
            end
            else if (sel(reg_addr_i, `ADDR_SWALLOW))
            begin
                swallow_ff <= reg_wdata_i[5:0];
            end
            else if (sel(reg_addr_i, `ADDR_FB_LOW))
            begin
                fb_low_ff <= reg_wdata_i;
            end
            else if (sel(reg_addr_i, `ADDR_FB_HIGH))
            begin
                fb_high_ff <= reg_wdata_i[4:0];
            end
            else if (sel(reg_addr_i, `ADDR_DIV_CTRL))
            begin
                div_ctrl_ff <= reg_wdata_i[7:3];
            end
        end
    end

    // read mux, unused bits and unmapped addresses read zero
    always @*
    begin
        nxt_rdata = 8'h00;
        if (sel(reg_addr_i, `ADDR_PLL_MODE))
        begin
            nxt_rdata = {6'h00, pll_mode_ff};
        end
        else if (sel(reg_addr_i, `ADDR_REF_LOW))
        begin
            nxt_rdata = ref_low_ff;
        end
        else if (sel(reg_addr_i, `ADDR_REF_HIGH))
        begin
            nxt_rdata = {2'h0, ref_high_ff};
        end
        else if (sel(reg_addr_i, `ADDR_SWALLOW))
        begin
            nxt_rdata = {2'h0, swallow_ff};
        end
        else if (sel(reg_addr_i, `ADDR_FB_LOW))
        begin
            nxt_rdata = fb_low_ff;
        end
        else if (sel(reg_addr_i, `ADDR_FB_HIGH))
        begin
            nxt_rdata = {3'h0, fb_high_ff};
        end
        else if (sel(reg_addr_i, `ADDR_DIV_CTRL))
        begin
            nxt_rdata = {div_ctrl_ff, 3'h0};
        end
    end

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (clk_en_i && reg_rd_i)
        begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    // two flops before use, third flop only for edge detect
    // reset low to match the idle pin level, so no false edge after reset
    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            ref_sync_ff <= 3'h0;
        end
        else if (clk_en_i)
        begin
            ref_sync_ff <= {ref_sync_ff[1:0], ref_clk_i};
        end
    end

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            pre_sync_ff <= 3'h0;
        end
        else if (clk_en_i)
        begin
            pre_sync_ff <= {pre_sync_ff[1:0], prescaler_clk_i};
        end
    end

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            dual_sync_ff <= 2'h0;
        end
        else if (clk_en_i)
        begin
            dual_sync_ff <= {dual_sync_ff[0], dual_modulus_mode_i};
        end
    end

    assign ref_tick  = ref_sync_ff[1] & ~ref_sync_ff[2];
    assign pre_tick  = pre_sync_ff[1] & ~pre_sync_ff[2];
    assign dual_mode = dual_sync_ff[1];

    // control field decode
    assign cp_mid   = div_ctrl_ff[`CTRL_CP_MID_BIT - 3];
    assign rst_ref  = div_ctrl_ff[`CTRL_RST_REF_BIT - 3];
    assign rst_fb   = div_ctrl_ff[`CTRL_RST_FB_BIT - 3];
    assign rst_all  = div_ctrl_ff[`CTRL_RST_ALL_BIT - 3];
    assign bypass   = div_ctrl_ff[`CTRL_BYPASS_BIT - 3];
    assign loop_run = (pll_mode_ff == `MODE_NORMAL);

    assign ref_div_val = {ref_high_ff, ref_low_ff};
    assign fb_div_val  = {fb_high_ff, fb_low_ff};

    // mode decode, the loop runs only in normal mode
    always @*
    begin
        nxt_pll_normal   = 1'b0;
        nxt_pll_pd_async = 1'b0;
        nxt_pll_pd_sync  = 1'b0;
        case (pll_mode_ff)
            `MODE_NORMAL:
            begin
                nxt_pll_normal = 1'b1;
            end
            `MODE_PD_ASYNC:
            begin
                nxt_pll_pd_async = 1'b1;
            end
            `MODE_PD_SYNC:
            begin
                nxt_pll_pd_sync = 1'b1;
            end
            default:
            begin
                nxt_pll_pd_sync = 1'b0;
            end
        endcase
        // any mode but normal keeps both counter chains held
        nxt_ref_hold = rst_ref | rst_all | ~loop_run;
        nxt_fb_hold  = rst_fb | rst_all | ~loop_run;
    end

    // mode, charge pump and hold outputs
    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            pll_normal_o             <= 1'b0;
            pll_pd_async_o           <= 1'b1;
            pll_pd_sync_o            <= 1'b0;
            charge_pump_output_mid_o <= 1'b0;
            ref_hold_o               <= 1'b1;
            fb_hold_o                <= 1'b1;
        end
        else if (clk_en_i)
        begin
            pll_normal_o             <= nxt_pll_normal;
            pll_pd_async_o           <= nxt_pll_pd_async;
            pll_pd_sync_o            <= nxt_pll_pd_sync;
            charge_pump_output_mid_o <= cp_mid;
            ref_hold_o               <= nxt_ref_hold;
            fb_hold_o                <= nxt_fb_hold;
        end
    end

    // reference counter
    ref_divider u_ref_divider
    (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .hold_i      (ref_hold_o),
        .tick_i      (ref_tick),
        .div_val_i   (ref_div_val),
        .div_pulse_o (ref_pulse_o)
    );

    // swallow and main feedback counters
    feedback_divider u_feedback_divider
    (
        .core_clk_i          (core_clk_i),
        .reset_n_i           (reset_n_i),
        .clk_en_i            (clk_en_i),
        .hold_i              (fb_hold_o),
        .dual_modulus_mode_i (dual_mode),
        .bypass_i            (bypass),
        .swallow_i           (swallow_ff),
        .main_i              (fb_div_val),
        .tick_i              (pre_tick),
        .modulus_hi_o        (modulus_hi_o),
        .fb_pulse_o          (fb_pulse_o)
    );

endmodule
`default_nettype wire

//--- verification/pll_divider_control_assertions.sv
// assertions for the pll divider control block
`timescale 1ns/100ps
`default_nettype none
`include "pll_div_consts.vh"
module pll_divider_control_checker
(
    // clock, reset and register port
    input wire logic               core_clk_i, reset_n_i, clk_en_i, reg_wr_i, reg_rd_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]         reg_wdata_i, reg_rdata_o,
    // pins and outputs
    input wire logic               ref_clk_i, prescaler_clk_i, dual_modulus_mode_i,
    input wire logic               pll_normal_o, pll_pd_async_o, pll_pd_sync_o,
    input wire logic               charge_pump_output_mid_o, ref_hold_o, fb_hold_o,
    input wire logic               ref_pulse_o, fb_pulse_o, modulus_hi_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic mode_wr = reg_wr_i && clk_en_i && reg_addr_i == `ADDR_PLL_MODE;
    wire logic ctrl_wr = reg_wr_i && clk_en_i && reg_addr_i == `ADDR_DIV_CTRL;
    wire logic rd_en   = reg_rd_i && clk_en_i;
    mode_decode_a: assert property (mode_wr ##1 clk_en_i |=>
        pll_normal_o == ($past(reg_wdata_i[1:0], 2) == 2'h0) &&
        pll_pd_sync_o == ($past(reg_wdata_i[1:0], 2) == 2'h3))
        else $error("mode decode wrong after mode write");
    held_unless_normal_a: assert property (!pll_normal_o |-> ref_hold_o && fb_hold_o)
        else $error("counters run outside normal mode");
    mode_exclusive_a: assert property ($onehot0({pll_normal_o, pll_pd_async_o, pll_pd_sync_o}))
        else $error("more than one mode flag");
    cp_mid_a: assert property (ctrl_wr ##1 clk_en_i |=>
        charge_pump_output_mid_o == $past(reg_wdata_i[7], 2))
        else $error("charge pump midpoint wrong");
    ref_hold_set_a: assert property (ctrl_wr && (reg_wdata_i[6] || reg_wdata_i[4])
        ##1 clk_en_i |=> ref_hold_o) else $error("reference hold missing");
    fb_hold_set_a: assert property (ctrl_wr && (reg_wdata_i[5] || reg_wdata_i[4])
        ##1 clk_en_i |=> fb_hold_o) else $error("feedback hold missing");
    ref_quiet_a: assert property (ref_hold_o [*2] |-> !ref_pulse_o)
        else $error("reference pulse while held");
    fb_quiet_a: assert property (fb_hold_o [*2] |-> !fb_pulse_o)
        else $error("feedback pulse while held");
    unused_high_a: assert property (rd_en && reg_addr_i == `ADDR_REF_HIGH |=>
        reg_rdata_o[7:6] == 2'b00) else $error("unused bits read nonzero");
    unmapped_read_a: assert property (rd_en && (reg_addr_i < `ADDR_PLL_MODE ||
        reg_addr_i > `ADDR_DIV_CTRL) |=> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");
    fixed_low_ratio_a: assert property (!dual_modulus_mode_i [*4] |-> !modulus_hi_o)
        else $error("high ratio in fixed divide");
    cover property (mode_wr);
    cover property (ref_pulse_o);
    cover property (modulus_hi_o);
endmodule
bind pll_divider_control pll_divider_control_checker chk_u (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .ref_clk_i(ref_clk_i), .prescaler_clk_i(prescaler_clk_i),
    .dual_modulus_mode_i(dual_modulus_mode_i), .pll_normal_o(pll_normal_o),
    .pll_pd_async_o(pll_pd_async_o), .pll_pd_sync_o(pll_pd_sync_o),
    .charge_pump_output_mid_o(charge_pump_output_mid_o), .ref_hold_o(ref_hold_o),
    .fb_hold_o(fb_hold_o), .ref_pulse_o(ref_pulse_o), .fb_pulse_o(fb_pulse_o),
    .modulus_hi_o(modulus_hi_o));
`default_nettype wire

//--- verification/pll_divider_control_bench.sv
// self-checking bench for the pll divider control block
`timescale 1ns/100ps
`default_nettype none
`include "pll_div_consts.vh"
module pll_divider_control_bench;
    logic       clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       ref_clk = 1'b0, pre_clk = 1'b0, dual = 1'b0, ce = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    wire  [7:0] rdata;
    wire        normal, pd_async, pd_sync, cp_mid, ref_hold, fb_hold, ref_p, fb_p, mod_hi;
    logic [7:0] model [0:7];
    integer     n_errors = 0, checks_done = 0, n_ref = 0, n_fb = 0, n_mod = 0, i, r;
    always #2.5 clk = ~clk;
    pll_divider_control dut_u (.core_clk_i(clk), .reset_n_i(reset_n), .clk_en_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .ref_clk_i(ref_clk), .prescaler_clk_i(pre_clk),
        .dual_modulus_mode_i(dual), .pll_normal_o(normal), .pll_pd_async_o(pd_async),
        .pll_pd_sync_o(pd_sync), .charge_pump_output_mid_o(cp_mid), .ref_hold_o(ref_hold),
        .fb_hold_o(fb_hold), .ref_pulse_o(ref_p), .fb_pulse_o(fb_p), .modulus_hi_o(mod_hi));
    // running counts of divider events
    always @(posedge clk)
    begin
        n_ref <= n_ref + (ref_p === 1'b1);
        n_fb <= n_fb + (fb_p === 1'b1);
        n_mod <= n_mod + (mod_hi === 1'b1);
    end
    function automatic logic [7:0] mask_of(input logic [9:0] a);
        case (a)
            10'h010: mask_of = 8'h03;
            10'h011, 10'h014: mask_of = 8'hff;
            10'h012, 10'h013: mask_of = 8'h3f;
            10'h015: mask_of = 8'h1f;
            10'h016: mask_of = 8'hf8;
            default: mask_of = 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [9:0] a);
        exp_rd = (a[9:3] == 7'h02) ? model[a[2:0]] : 8'h00;
    endfunction
    task automatic wrap_up;
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        model[a[2:0]] = (a[9:3] == 7'h02) ? (d & mask_of(a)) : model[a[2:0]];
    endtask
    task automatic rd_reg(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("read data", {8'h00, rdata}, {8'h00, exp_rd(a)});
        @(posedge clk);
        @(negedge clk);
        chk("read hold", {8'h00, rdata}, {8'h00, exp_rd(a)});
    endtask
    // toggles both divider inputs n times, four core cycles high and four low
    task automatic run_edges(input integer n, input integer er, input integer ef, input bit em);
        integer b_ref, b_fb, b_mod;
        // let outputs of the last write settle before taking baselines
        repeat (2) @(posedge clk);
        b_ref = n_ref;
        b_fb = n_fb;
        b_mod = n_mod;
        repeat (n)
        begin
            @(posedge clk);
            ref_clk <= 1'b1;
            pre_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ref_clk <= 1'b0;
            pre_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        chk("reference pulses", 16'(n_ref - b_ref), 16'(er));
        chk("feedback pulses", 16'(n_fb - b_fb), 16'(ef));
        chk("high ratio seen", {15'h0, n_mod != b_mod}, {15'h0, em});
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial
    begin
        r = $urandom(47);
        model = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("state after reset", {12'h0, pd_async, ref_hold, fb_hold, normal}, 16'h000e);
        for (i = 0; i < 8; i++)
            rd_reg(10'h010 + 10'(i));
        rd_reg(10'h3ff);
        rd_reg(10'h00f);
        for (i = 0; i < 40; i++)
        begin
            wr_reg(10'h010 + 10'($urandom_range(7)), 8'($urandom));
            rd_reg(10'h010 + 10'($urandom_range(7)));
        end
        @(negedge clk);
        chk("midpoint", {15'h0, cp_mid}, {15'h0, model[6][7]});
        chk("ref hold", {15'h0, ref_hold}, {15'h0, model[6][6] | model[6][4] | model[0] != 0});
        chk("fb hold", {15'h0, fb_hold}, {15'h0, model[6][5] | model[6][4] | model[0] != 0});
        wr_reg(10'h016, 8'h00);
        // a write while the clock enable is low must be lost
        ce <= 1'b0;
        wr_reg(10'h016, 8'hf8);
        ce <= 1'b1;
        model[6] = 8'h00;
        rd_reg(10'h016);
        for (i = 0; i < 4; i++)
        begin
            wr_reg(10'h010, 8'(i));
            @(posedge clk);
            @(negedge clk);
            chk("mode flags", {11'h0, normal, pd_async, pd_sync, ref_hold, fb_hold},
                {11'h0, i == 0, i == 1, i == 3, i != 0, i != 0});
        end
        wr_reg(10'h016, 8'h10);
        wr_reg(10'h011, 8'h03);
        wr_reg(10'h012, 8'h00);
        wr_reg(10'h014, 8'h04);
        wr_reg(10'h015, 8'h00);
        wr_reg(10'h013, 8'h00);
        wr_reg(10'h010, 8'h00);
        wr_reg(10'h016, 8'h00);
        run_edges(12, 4, 3, 1'b0);
        wr_reg(10'h016, 8'h40);
        run_edges(12, 0, 3, 1'b0);
        wr_reg(10'h016, 8'h20);
        run_edges(12, 4, 0, 1'b0);
        wr_reg(10'h016, 8'h10);
        run_edges(12, 0, 0, 1'b0);
        wr_reg(10'h016, 8'h08);
        run_edges(12, 4, 12, 1'b0);
        wr_reg(10'h016, 8'h00);
        dual <= 1'b1;
        wr_reg(10'h013, 8'h02);
        run_edges(12, 4, 3, 1'b1);
        wr_reg(10'h013, 8'h00);
        run_edges(12, 4, 3, 1'b0);
        wr_reg(10'h012, 8'hc1);
        wr_reg(10'h011, 8'h00);
        wr_reg(10'h015, 8'he1);
        wr_reg(10'h014, 8'h00);
        run_edges(256, 1, 1, 1'b0);
        wr_reg(10'h010, 8'h03);
        run_edges(12, 0, 0, 1'b0);
        wrap_up;
    end
endmodule
`default_nettype wire
